/* File: rtl/rtchold_cfg.svh */
/*
  Timing and reset constants for the counter hold block.
  Assumes inclusion by its bare name from the package and the design.
*/
`ifndef RTCHOLD_CFG_SVH
`define RTCHOLD_CFG_SVH

// Sub-second prescaler: a 16-bit counter wraps once per second
`define RTCHOLD_SUBSEC_WIDTH 16
`define RTCHOLD_SUBSEC_RESET 16'h0000
// Calendar counter reset value (seconds count width)
`define RTCHOLD_CAL_WIDTH 32
`define RTCHOLD_CAL_RESET 32'h0000_0000
// Cycles of grant lag after a recent run enable or standby exit
`define RTCHOLD_SLOW_LAG 2'h2

`endif

/* File: rtl/rtchold_pkg.sv */
/*
  Types for the counter hold block.
  Assumes rtchold_cfg.svh is on the include path.
*/
`include "rtchold_cfg.svh"

package rtchold_pkg;
  // Software write request toward the calendar
  typedef struct packed {
    logic valid;
    logic [`RTCHOLD_CAL_WIDTH-1:0] data;
  } rtchold_write_t;

  // Hold handshake state
  typedef enum logic [1:0] {
    RTCHOLD_RUN,
    RTCHOLD_LAG,
    RTCHOLD_HELD
  } rtchold_state_t;
endpackage

/* File: rtl/rtchold_core.sv */
/*
  Counter hold logic of a real-time clock: freezes the calendar count on
  request, grants access, and defers a sub-second overflow seen during hold.
  Assumes all inputs come from logic on ref_clk_i; the tick enable is a
  one-cycle pulse at the prescaler rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtchold_cfg.svh"

// Summary of operation
// - Request low counts normally; request high freezes the calendar counters.
// - Hold status asserts one clock after the request, or two just after run enable or standby exit.
// - Overflow during hold is kept pending and applied after release.
// - Seconds write during hold discards the pending overflow.
// - Request right after run enable may take two clocks to grant.
// - Request right after standby exit may take two clocks to grant.
module rtchold_core (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Prescaler tick and controls
  input wire logic tick_en_i,
  input wire logic rtc_run_enable_i,
  input wire logic standby_exit_i,
  input wire logic counter_hold_request_i,
  // Seconds count write port
  input wire rtchold_pkg::rtchold_write_t seconds_write_i,
  // Status and count
  output logic counter_hold_status_o,
  output logic [`RTCHOLD_CAL_WIDTH-1:0] seconds_count_o,
  output logic [`RTCHOLD_SUBSEC_WIDTH-1:0] subsec_count_o
);
  import rtchold_pkg::*;

  // Hold handshake state and slow-grant countdown
  rtchold_state_t state, next_state;
  logic [1:0] lag, next_lag;
  // One-cycle window after run enable rises or standby ends
  logic run_rise;
  logic recent, next_recent;
  // Calendar, deferred carry and prescaler
  logic pending, next_pending;
  logic [`RTCHOLD_CAL_WIDTH-1:0] cal, next_cal;
  logic [`RTCHOLD_SUBSEC_WIDTH-1:0] sub, next_sub;
  logic sub_step;
  logic overflow;

  // Prescaler advances only on a tick while the clock is enabled
  assign sub_step = tick_en_i && rtc_run_enable_i;
  // Wrap of the all-ones count is the one-second carry
  assign overflow = sub_step && (&sub);

  // Run enable edge; its history follows the pin through reset
  rtchold_rise_detect #(
    .WIDTH(1)
  ) u_run_rise (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .level_i(rtc_run_enable_i),
    .rise_o(run_rise)
  );

  // Recent-event window: open for the cycle after either event
  always_comb begin
    next_recent = run_rise || standby_exit_i;
  end

  // Window register, closed by reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      recent <= 1'b0;
    end else begin
      recent <= next_recent;
    end
  end

  // Hold handshake; a request inside the window waits one extra cycle,
  // which keeps the grant within the two-cycle bound after a restart.
  // Normal walk: request seen on edge n, status high from edge n+1.
  always_comb begin
    next_state = state;
    next_lag = lag;
    unique case (state)
      RTCHOLD_RUN: begin
        if (counter_hold_request_i) begin
          if (recent) begin
            next_state = RTCHOLD_LAG;
            next_lag = `RTCHOLD_SLOW_LAG - 2'h1;
          end else begin
            next_state = RTCHOLD_HELD;
          end
        end
      end
      RTCHOLD_LAG: begin
        if (!counter_hold_request_i) begin
          next_state = RTCHOLD_RUN;
        end else if (lag <= 2'h1) begin
          next_state = RTCHOLD_HELD;
        end else begin
          next_lag = lag - 2'h1;
        end
      end
      RTCHOLD_HELD: begin
        if (!counter_hold_request_i) begin
          next_state = RTCHOLD_RUN;
        end
      end
      default: begin
        // Unused code: fall back to counting
        next_state = RTCHOLD_RUN;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= RTCHOLD_RUN;
      lag <= 2'h0;
    end else begin
      state <= next_state;
      lag <= next_lag;
    end
  end

  // Prescaler keeps running through a hold, so a long hold costs time
  always_comb begin
    next_sub = sub;
    if (sub_step) begin
      next_sub = sub + `RTCHOLD_SUBSEC_WIDTH'(1);
    end
  end

  // Prescaler register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sub <= `RTCHOLD_SUBSEC_RESET;
    end else begin
      sub <= next_sub;
    end
  end

  // Calendar and deferred carry.
  // Limitation: one carry is kept, so a hold across two wraps loses one.
  // A write in hold clears the carry, as the new value supersedes it.
  always_comb begin
    next_cal = cal;
    next_pending = pending;
    if (counter_hold_request_i) begin
      // Calendar frozen; remember a wrap for later
      if (overflow) begin
        next_pending = 1'b1;
      end
      // A seconds write wins over a simultaneous overflow, by design
      if (seconds_write_i.valid) begin
        next_cal = seconds_write_i.data;
        next_pending = 1'b0;
      end
    end else begin
      // Released: apply deferred and live carries together
      next_cal = cal + `RTCHOLD_CAL_WIDTH'(pending) + `RTCHOLD_CAL_WIDTH'(overflow);
      next_pending = 1'b0;
      if (seconds_write_i.valid) begin
        // Unheld writes are still honoured; software should hold first
        next_cal = seconds_write_i.data;
      end
    end
  end

  // Calendar registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cal <= `RTCHOLD_CAL_RESET;
      pending <= 1'b0;
    end else begin
      cal <= next_cal;
      pending <= next_pending;
    end
  end

  // Status is registered state, not the raw request
  assign counter_hold_status_o = (state == RTCHOLD_HELD);
  assign seconds_count_o = cal;
  assign subsec_count_o = sub;
endmodule // rtchold_core

// Rising-edge finder for level controls on ref_clk_i.
// History loads the live level in reset, so a control already high
// when reset ends is not taken for a fresh edge.
module rtchold_rise_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Levels watched and edges found
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] rise_o
);
  import rtchold_pkg::*;

  logic [WIDTH-1:0] last, next_last;

  // Edge is high in the first cycle the level is seen high
  always_comb begin
    next_last = level_i;
    rise_o = level_i & ~last;
  end

  // History register; reset tracks the pin, avoiding a false edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      last <= level_i;
    end else begin
      last <= next_last;
    end
  end
endmodule // rtchold_rise_detect
`default_nettype wire

/* File: test/rtcah_asserts.sv */
/* Port checker for rtchold_core.
   Assumes it is bound to every instance of that core. */
`timescale 1ns/1ps
`default_nettype none
module rtcah_asserts (
  // Watched ports
  input wire logic ref_clk_i, reset_i, tick_en_i, rtc_run_enable_i,
  input wire logic standby_exit_i, counter_hold_request_i, counter_hold_status_o,
  input wire rtchold_pkg::rtchold_write_t seconds_write_i,
  input wire logic [31:0] seconds_count_o,
  input wire logic [15:0] subsec_count_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Freeze and grant timing
  a_hold_freeze: assert property (counter_hold_request_i && !seconds_write_i.valid
    |=> $stable(seconds_count_o)) else $error("count moved in hold");
  a_grant_fast: assert property ($rose(counter_hold_request_i) && !$past(standby_exit_i)
    && $past(rtc_run_enable_i, 2) |=> counter_hold_status_o) else $error("late grant");
  a_grant_slow: assert property ($rose(counter_hold_request_i) ##1 counter_hold_request_i
    |-> ##[0:1] counter_hold_status_o) else $error("grant beyond two");
  a_status_hold: assert property (counter_hold_status_o && counter_hold_request_i
    |=> counter_hold_status_o) else $error("grant lost");
  a_status_drop: assert property ($fell(counter_hold_request_i)
    |=> !counter_hold_status_o) else $error("grant stuck");
  a_write_load: assert property (counter_hold_request_i && seconds_write_i.valid
    |=> seconds_count_o == $past(seconds_write_i.data)) else $error("write lost");
  // Sub-second count never stops for a hold
  a_subsec_run: assert property (rtc_run_enable_i && tick_en_i
    |=> subsec_count_o == 16'($past(subsec_count_o) + 16'h0001)) else $error("subsec stalled");
endmodule // rtcah_asserts
bind rtchold_core rtcah_asserts u_chk (.*);
`default_nettype wire

/* File: test/rtc_counter_access_hold_tb_top.sv */
/* Bench for the counter hold block.
   Assumes the package and core are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module rtc_counter_access_hold_tb_top;
  import rtchold_pkg::*;
  // Stimulus, outputs, tallies
  logic clk = 0, rst = 1, tick = 1, run = 1, sb = 0, req = 0, stat;
  rtchold_write_t wr = '0;
  logic [31:0] sec;
  logic [15:0] sub, sub_mark;
  int err_count = 0, compares = 0;
  always #50 clk = ~clk;
  rtchold_core uut (.ref_clk_i(clk), .reset_i(rst), .tick_en_i(tick), .rtc_run_enable_i(run),
    .standby_exit_i(sb), .counter_hold_request_i(req), .seconds_write_i(wr),
    .counter_hold_status_o(stat), .seconds_count_o(sec), .subsec_count_o(sub));
  task complete_run;
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hold across a wrap; the lost second must come back on release
  task overflow_defer;
    while (sub !== 16'hfff0) @(negedge clk);
    req = 1;
    while (sub !== 16'h0010) @(negedge clk);
    `CHK("sec", 32'h0, sec)
    req = 0;
    @(negedge clk);
    `CHK("sec", 32'h1, sec)
  endtask
  // Grant, write, freeze, release
  task hold_walk;
    req = 1;
    @(negedge clk);
    `CHK("stat", 1'h1, stat)
    sub_mark = sub;
    wr = {1'h1, 32'h0000_00a5};
    @(negedge clk);
    wr = '0;
    `CHK("sec", 32'ha5, sec)
    @(negedge clk);
    `CHK("sec", 32'ha5, sec)
    `CHK("sub", 16'(sub_mark + 16'h0002), sub)
    req = 0;
    @(negedge clk);
    `CHK("stat", 1'h0, stat)
  endtask
  // Request just after standby exit or run start
  task lag_grant(input logic via_sb);
    if (via_sb) sb = 1; else run = 0;
    @(negedge clk);
    sb = 0;
    run = 1;
    if (!via_sb) @(negedge clk);
    req = 1;
    @(negedge clk);
    `CHK("stat", 1'h0, stat)
    @(negedge clk);
    `CHK("stat", 1'h1, stat)
    req = 0;
    @(negedge clk);
    `CHK("stat", 1'h0, stat)
  endtask
  // Watchdog well past one wrap of the sub-second count
  initial begin
    #8_000_000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    overflow_defer();
    hold_walk();
    lag_grant(1'h1);
    lag_grant(1'h0);
    complete_run();
  end
endmodule // rtc_counter_access_hold_tb_top
`default_nettype wire
